// ==== inc/crp_pkg.sv ====
// constants and carrier types of the clock, reset and power controller
package crp_pkg;

	// timing at the 10 MHz core clock
	localparam int CLK_NS = 100;
	localparam int LVD_FILT_NS = 5000;
	localparam int LVD_FILT_CYC = (LVD_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] LVD_LAST = 6'(LVD_FILT_CYC - 1);
	localparam int START_CYC = 4096;
	localparam logic [12:0] START_LAST = 13'(START_CYC - 1);
	localparam int WAKE_UNIT_DEF = 4096;

	// register indexes, byte address is four times the index
	localparam logic [5:0] IDX_CPU_DIV = 6'h2E;
	localparam logic [5:0] IDX_OPT_CLK = 6'h30;
	localparam logic [5:0] IDX_OPT_TRIM = 6'h31;
	localparam logic [5:0] IDX_OPT_LVD = 6'h32;
	localparam logic [5:0] IDX_OPT_WAKE = 6'h33;
	localparam logic [5:0] IDX_STATUS = 6'h34;

	// field positions
	localparam int POS_GAIN = 2;
	localparam int POS_ST = 0;
	localparam int POS_CAUSE = 3;
	localparam int POS_SEL = 5;
	localparam int POS_LVD = 7;
	localparam int POS_RST = 8;

	// values after reset
	localparam logic [5:0] RST_CPU_DIV = 6'h00;
	localparam logic [1:0] RST_CLK_MODE = 2'h0;
	localparam logic [2:0] RST_GAIN = 3'h0;
	localparam logic [5:0] RST_TRIM = 6'h14;
	localparam logic [1:0] RST_LVD_LVL = 2'h2;
	localparam logic [7:0] RST_WAKE = 8'h00;
	localparam logic [15:0] VEC_RESET = 16'h0000;

	// clock mode and detector level codes
	localparam logic [1:0] CKM_INT = 2'h0;
	localparam logic [1:0] CKM_EXT = 2'h1;
	localparam logic [1:0] LVL_OFF = 2'h0;

	typedef enum logic [1:0] {
		CAUSE_POR = 2'b00,
		CAUSE_EXT = 2'b01,
		CAUSE_WDOG = 2'b10,
		CAUSE_LVD = 2'b11
	} crp_cause_t;

	typedef enum logic [2:0] {
		ST_DLY1 = 3'b000,
		ST_DLY2 = 3'b001,
		ST_RUN = 3'b010,
		ST_WAIT = 3'b011,
		ST_HALT = 3'b100
	} crp_st_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} crp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} crp_apb_rsp_t;

	typedef struct packed {
		logic [1:0] ext_s;
		logic [1:0] por_s;
		logic [1:0] sup_s;
		logic [1:0] lvd_s;
		logic [1:0] nmi_s;
		logic [1:0] pta_s;
		logic [1:0] ptb_s;
		crp_st_t st;
		logic [12:0] cnt;
		logic [7:0] pre;
		logic [5:0] lvd_cnt;
		logic lvd_act;
		logic in_rst;
		crp_cause_t cause;
		logic [1:0] wake;
		logic [1:0] clk_sel;
		logic [5:0] cpu_cnt;
		logic [5:0] cpu_div;
		logic [1:0] clk_mode;
		logic [2:0] gain;
		logic [5:0] trim;
		logic [1:0] lvd_lvl;
		logic [7:0] wake_cnt;
		logic core_rst_n;
		logic osc_en;
		logic periph_en;
		logic cpu_en;
		logic lvd_en;
		logic start;
		logic [1:0] resume;
		logic [15:0] boot_addr;
		crp_apb_rsp_t rsp;
	} crp_state_t;

endpackage : crp_pkg

// ==== rtl/crp_ctrl.sv ====
// clock, reset and power-saving sequencer with apb option registers
`timescale 1ns/10ps

module crp_ctrl
	import crp_pkg::*;
#(
	parameter int WAKE_UNIT = WAKE_UNIT_DEF
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// register bus
	input wire crp_apb_req_t apb_req_in,
	output crp_apb_rsp_t apb_rsp_out,
	// reset and supply sources
	input wire logic ext_rst_n_in,
	input wire logic por_in,
	input wire logic supply_good_in,
	input wire logic lvd_below_in,
	input wire logic wdog_rst_in,
	input wire logic wdog_en_in,
	// core requests and interrupts
	input wire logic wait_req_in,
	input wire logic halt_req_in,
	input wire logic irq_in,
	input wire logic nmi_in,
	input wire logic [1:0] port_irq_in,
	input wire logic [1:0] port_mask_in,
	// clock and reset controls
	output logic core_rst_n_out,
	output logic start_pulse_out,
	output logic [15:0] boot_addr_out,
	output logic [1:0] resume_irq_out,
	output logic osc_en_out,
	output logic [1:0] clk_sel_out,
	output logic [5:0] osc_trim_out,
	output logic [2:0] osc_gain_out,
	output logic cpu_clk_en_out,
	output logic periph_clk_en_out,
	output logic lvd_en_out,
	output logic [1:0] lvd_level_out
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// last count of the cpu divider
	function automatic logic [5:0] crp_div_last(input logic [5:0] f);
		case (f)
			6'h00: return 6'h00;
			6'h01: return 6'h01;
			6'h02: return 6'h03;
			6'h04: return 6'h07;
			6'h08: return 6'h0F;
			6'h10: return 6'h1F;
			default: return 6'h3F;
		endcase
	endfunction : crp_div_last

	crp_state_t s;
	crp_state_t n;
	logic ext_req;
	logic por_req;
	logic halt_wake;
	logic [31:0] rd;
	logic hit;
	logic [5:0] idx;

	assign ext_req = !s.ext_s[1];
	assign por_req = s.por_s[1];
	assign halt_wake = s.nmi_s[1] || (s.pta_s[1] && port_mask_in[0])
		|| (s.ptb_s[1] && port_mask_in[1]);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = s;
		idx = apb_req_in.paddr[7:2];
		rd = 32'h0000_0000;
		hit = 1'b1;
		n.ext_s = {s.ext_s[0], ext_rst_n_in};
		n.por_s = {s.por_s[0], por_in};
		n.sup_s = {s.sup_s[0], supply_good_in};
		n.lvd_s = {s.lvd_s[0], lvd_below_in};
		n.nmi_s = {s.nmi_s[0], nmi_in};
		n.pta_s = {s.pta_s[0], port_irq_in[0]};
		n.ptb_s = {s.ptb_s[0], port_irq_in[1]};
		n.start = 1'b0;
		n.resume = 2'b00;

		// detector filter, untouched by its own reset
		if (s.st == ST_HALT || s.lvd_lvl == LVL_OFF) begin
			n.lvd_cnt = 6'h00;
			n.lvd_act = 1'b0;
		end else if (s.lvd_s[1] != s.lvd_act) begin
			if (s.lvd_cnt == LVD_LAST) begin
				n.lvd_act = s.lvd_s[1];
				n.lvd_cnt = 6'h00;
			end else begin
				n.lvd_cnt = s.lvd_cnt + 6'h01;
			end
		end else begin
			n.lvd_cnt = 6'h00;
		end

		// apb access phase, answer one cycle later
		unique case (idx)
			IDX_CPU_DIV: rd[5:0] = s.cpu_div;
			IDX_OPT_CLK: rd[4:0] = {s.gain, s.clk_mode};
			IDX_OPT_TRIM: rd[5:0] = s.trim;
			IDX_OPT_LVD: rd[1:0] = s.lvd_lvl;
			IDX_OPT_WAKE: rd[7:0] = s.wake_cnt;
			IDX_STATUS: begin
				rd[POS_ST +: 3] = s.st;
				rd[POS_CAUSE +: 2] = s.cause;
				rd[POS_SEL +: 2] = s.clk_sel;
				rd[POS_LVD] = s.lvd_act;
				rd[POS_RST] = s.in_rst;
			end
			default: hit = 1'b0;
		endcase
		n.rsp.pready = 1'b0;
		n.rsp.pslverr = 1'b0;
		if (apb_req_in.psel && apb_req_in.penable && !s.rsp.pready) begin
			n.rsp.pready = 1'b1;
			n.rsp.pslverr = !hit;
			n.rsp.prdata = apb_req_in.pwrite ? 32'h0000_0000 : rd;
		end
		if (apb_req_in.psel && apb_req_in.penable && s.rsp.pready && apb_req_in.pwrite) begin
			unique case (idx)
				IDX_CPU_DIV: n.cpu_div = apb_req_in.pwdata[5:0];
				IDX_OPT_CLK: begin
					n.clk_mode = apb_req_in.pwdata[1:0];
					n.gain = apb_req_in.pwdata[POS_GAIN +: 3];
				end
				IDX_OPT_TRIM: n.trim = apb_req_in.pwdata[5:0];
				IDX_OPT_LVD: n.lvd_lvl = apb_req_in.pwdata[1:0];
				IDX_OPT_WAKE: n.wake_cnt = apb_req_in.pwdata[7:0];
				default: ;
			endcase
		end

		// sequencer
		unique case (s.st)
			ST_DLY1: begin
				if (s.sup_s[1]) begin
					if (s.cnt == START_LAST) begin
						n.cnt = 13'h0000;
						n.pre = 8'h00;
						n.st = (s.clk_mode == CKM_INT) ? ST_RUN : ST_DLY2;
					end else begin
						n.cnt = s.cnt + 13'h0001;
					end
				end
			end
			ST_DLY2: begin
				if (s.cnt == 13'(WAKE_UNIT - 1)) begin
					n.cnt = 13'h0000;
					if (s.pre == s.wake_cnt) begin
						n.st = ST_RUN;
					end else begin
						n.pre = s.pre + 8'h01;
					end
				end else begin
					n.cnt = s.cnt + 13'h0001;
				end
			end
			ST_RUN: begin
				if (!s.in_rst && halt_req_in && !wdog_en_in) begin
					n.st = ST_HALT;
				end else if (!s.in_rst && wait_req_in) begin
					n.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (irq_in) begin
					n.st = ST_RUN;
				end
			end
			ST_HALT: begin
				if (halt_wake) begin
					n.st = ST_DLY1;
					n.cnt = 13'h0000;
					n.clk_sel = CKM_INT;
					n.wake = {s.pta_s[1] || s.ptb_s[1], s.nmi_s[1]};
				end
			end
			default: n.st = ST_DLY1;
		endcase

		// start-up complete: selected clock with reset release or resume, all in the same cycle
		if ((s.st == ST_DLY1 || s.st == ST_DLY2) && n.st == ST_RUN) begin
			n.clk_sel = s.clk_mode;
			n.resume = s.wake;
			n.wake = 2'b00;
			n.in_rst = 1'b0;
		end

		// reset merge
		if (ext_req || por_req) begin
			n.st = ST_DLY1;
			n.cnt = 13'h0000;
			n.pre = 8'h00;
			n.clk_sel = CKM_INT;
			n.wake = 2'b00;
			n.in_rst = 1'b1;
			n.cause = ext_req ? CAUSE_EXT : CAUSE_POR;
			n.cpu_div = RST_CPU_DIV;
		end else if (s.lvd_act || wdog_rst_in) begin
			n.st = ST_RUN;
			n.wake = 2'b00;
			n.in_rst = 1'b1;
			n.cause = s.lvd_act ? CAUSE_LVD : CAUSE_WDOG;
			n.cpu_div = RST_CPU_DIV;
		end else if (s.in_rst && s.st == ST_RUN) begin
			n.in_rst = 1'b0;
		end

		// outputs follow the next state
		n.start = s.in_rst && !n.in_rst;
		if (n.start) begin
			n.boot_addr = VEC_RESET;
		end
		n.core_rst_n = !n.in_rst;
		n.osc_en = n.st != ST_HALT;
		n.periph_en = n.st == ST_RUN || n.st == ST_WAIT;
		n.lvd_en = n.lvd_lvl != LVL_OFF && n.st != ST_HALT;
		if (n.st == ST_RUN) begin
			if (s.cpu_cnt == 6'h00) begin
				n.cpu_cnt = crp_div_last(n.cpu_div);
				n.cpu_en = 1'b1;
			end else begin
				n.cpu_cnt = s.cpu_cnt - 6'h01;
				n.cpu_en = 1'b0;
			end
		end else begin
			n.cpu_cnt = 6'h00;
			n.cpu_en = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.st <= ST_DLY1;
			s.in_rst <= 1'b1;
			s.cause <= CAUSE_POR;
			s.clk_sel <= CKM_INT;
			s.cpu_div <= RST_CPU_DIV;
			s.clk_mode <= RST_CLK_MODE;
			s.gain <= RST_GAIN;
			s.trim <= RST_TRIM;
			s.lvd_lvl <= RST_LVD_LVL;
			s.wake_cnt <= RST_WAKE;
			s.osc_en <= 1'b1;
			s.boot_addr <= VEC_RESET;
		end else begin
			s <= n;
		end
	end

	assign apb_rsp_out = s.rsp;
	assign core_rst_n_out = s.core_rst_n;
	assign start_pulse_out = s.start;
	assign boot_addr_out = s.boot_addr;
	assign resume_irq_out = s.resume;
	assign osc_en_out = s.osc_en;
	assign clk_sel_out = s.clk_sel;
	assign osc_trim_out = s.trim;
	assign osc_gain_out = s.gain;
	assign cpu_clk_en_out = s.cpu_en;
	assign periph_clk_en_out = s.periph_en;
	assign lvd_en_out = s.lvd_en;
	assign lvd_level_out = s.lvd_lvl;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_ext_rst;
		ext_req |=> (!core_rst_n_out && s.st == ST_DLY1 && s.cnt == 13'h0000);
	endproperty
	a_ext_rst: assert property (p_ext_rst) else $error("pin reset not taken");

	property p_int_first;
		s.st == ST_DLY1 |-> clk_sel_out == CKM_INT;
	endproperty
	a_int_first: assert property (p_int_first) else $error("start-up not on internal");

	property p_int_skip;
		(s.st == ST_DLY1 && s.cnt == START_LAST && s.sup_s[1] && !ext_req && !por_req
			&& !s.lvd_act && !wdog_rst_in)
		|=> (s.st == (($past(s.clk_mode) == CKM_INT) ? ST_RUN : ST_DLY2));
	endproperty
	a_int_skip: assert property (p_int_skip) else $error("second delay choice wrong");

	property p_fast_rst;
		(wdog_rst_in && !ext_req && !por_req) |=> (!core_rst_n_out && osc_en_out
			&& s.st == ST_RUN);
	endproperty
	a_fast_rst: assert property (p_fast_rst) else $error("fast reset path wrong");

	property p_lvd_hold;
		s.lvd_act |=> !core_rst_n_out;
	endproperty
	a_lvd_hold: assert property (p_lvd_hold) else $error("detector reset released");

	property p_lvd_filt;
		$changed(s.lvd_act) && s.st != ST_HALT && s.lvd_lvl != LVL_OFF
		|-> $past(s.lvd_cnt) == LVD_LAST;
	endproperty
	a_lvd_filt: assert property (p_lvd_filt) else $error("detector not filtered");

	property p_halt_lvd;
		s.st == ST_HALT |-> (!s.lvd_act && !lvd_en_out);
	endproperty
	a_halt_lvd: assert property (p_halt_lvd) else $error("detector active in halt");

	property p_wait_clk;
		s.st == ST_WAIT |-> (!cpu_clk_en_out && periph_clk_en_out && osc_en_out);
	endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("wait clocks wrong");

	property p_halt_osc;
		s.st == ST_HALT |-> (!osc_en_out && !periph_clk_en_out && !cpu_clk_en_out);
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("halt clocks wrong");

	property p_halt_wdog;
		(s.st == ST_RUN && wdog_en_in && halt_req_in) |=> s.st != ST_HALT;
	endproperty
	a_halt_wdog: assert property (p_halt_wdog) else $error("halt taken with watchdog");

	property p_masked;
		(s.st == ST_HALT && !halt_wake && !ext_req && !por_req && !wdog_rst_in)
		|=> s.st == ST_HALT;
	endproperty
	a_masked: assert property (p_masked) else $error("halt left without wake");

endmodule : crp_ctrl

// ==== tb/crp_far.sv ====
// reset circuit and supply model on the far side of the controller
`timescale 1ns/10ps
module crp_far (
	// clock and commands
	input wire logic core_clk_in,
	input wire logic por_cmd_in,
	input wire logic pin_cmd_in,
	input wire logic low_cmd_in,
	// levels seen by the controller
	output logic ext_rst_n_out,
	output logic por_out,
	output logic supply_good_out,
	output logic lvd_below_out
);
	int ramp = 0;
	// pin is input only, pull-up holds it high unless pressed
	assign ext_rst_n_out = pin_cmd_in ? 1'b0 : 1'b1;
	assign por_out = por_cmd_in;
	assign lvd_below_out = low_cmd_in;
	always @(posedge core_clk_in) begin
		if (por_cmd_in)
			ramp <= 0;
		else if (ramp < 20)
			ramp <= ramp + 1;
	end
	// supply good some cycles after power-on ends
	assign supply_good_out = (ramp >= 20);
endmodule : crp_far

// ==== tb/tb.sv ====
// self-checking bench of the clock, reset and power controller
`timescale 1ns/10ps
module tb;
	import crp_pkg::*;
	localparam int WU = 8;
	logic core_clk_in = 0;
	logic rst_n_in = 0;
	crp_apb_req_t req = '0;
	crp_apb_rsp_t rsp;
	logic por_cmd = 1, pin_cmd = 0, low_cmd = 0;
	logic ext_rst_n, por, sup_good, lvd_below;
	logic wdog_rst = 0, wdog_en = 0, wait_req = 0, halt_req = 0, irq = 0, nmi = 0;
	logic [1:0] port_irq = 0, port_mask = 0;
	logic core_rst_n, start_p, osc_en, cpu_en, per_en, lvd_en;
	logic [15:0] boot;
	logic [1:0] resume, clk_sel, lvd_lvl;
	logic [5:0] trim;
	logic [2:0] gain;
	crp_apb_rsp_t o_rsp;
	logic o_rst_n, o_start, o_osc, o_cpu, o_per, o_lvd;
	logic [15:0] o_boot;
	logic [1:0] o_resume, o_sel, o_lvl;
	logic [5:0] o_trim;
	logic [2:0] o_gain;
	logic [31:0] rd;
	logic err;
	int failures = 0, n_tests = 0, cyc = 0, n;
	logic [5:0] dv [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h2B};
	int ex [8] = '{128, 64, 32, 16, 8, 4, 2, 2};

	crp_far u_far (.core_clk_in(core_clk_in), .por_cmd_in(por_cmd), .pin_cmd_in(pin_cmd),
		.low_cmd_in(low_cmd), .ext_rst_n_out(ext_rst_n), .por_out(por),
		.supply_good_out(sup_good), .lvd_below_out(lvd_below));
	crp_ctrl #(.WAKE_UNIT(WU)) uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.apb_req_in(req), .apb_rsp_out(o_rsp), .ext_rst_n_in(ext_rst_n), .por_in(por),
		.supply_good_in(sup_good), .lvd_below_in(lvd_below), .wdog_rst_in(wdog_rst),
		.wdog_en_in(wdog_en), .wait_req_in(wait_req), .halt_req_in(halt_req),
		.irq_in(irq), .nmi_in(nmi), .port_irq_in(port_irq), .port_mask_in(port_mask),
		.core_rst_n_out(o_rst_n), .start_pulse_out(o_start), .boot_addr_out(o_boot),
		.resume_irq_out(o_resume), .osc_en_out(o_osc), .clk_sel_out(o_sel),
		.osc_trim_out(o_trim), .osc_gain_out(o_gain), .cpu_clk_en_out(o_cpu),
		.periph_clk_en_out(o_per), .lvd_en_out(o_lvd), .lvd_level_out(o_lvl));

	always #50 core_clk_in = ~core_clk_in;

	// design outputs as the next rising edge samples them, free of edge races
	always @(negedge core_clk_in) begin
		rsp = o_rsp;
		core_rst_n = o_rst_n;
		start_p = o_start;
		boot = o_boot;
		resume = o_resume;
		osc_en = o_osc;
		clk_sel = o_sel;
		trim = o_trim;
		gain = o_gain;
		cpu_en = o_cpu;
		per_en = o_per;
		lvd_en = o_lvd;
		lvd_lvl = o_lvl;
	end

	////////////////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			results();
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task tick(input int c);
		repeat (c) @(posedge core_clk_in);
	endtask : tick

	// one apb transfer, waits for pready, then one idle edge
	task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		req.psel <= 1;
		req.penable <= 0;
		req.pwrite <= wr;
		req.paddr <= {idx, 2'b00};
		req.pwdata <= wd;
		@(posedge core_clk_in);
		req.penable <= 1;
		do begin
			@(posedge core_clk_in);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 0;
		req.penable <= 0;
		@(posedge core_clk_in);
	endtask : apb

	task wait_rel;
		n = 0;
		while (core_rst_n !== 1'b1 && n < 20000) begin
			@(posedge core_clk_in);
			n++;
		end
	endtask : wait_rel

	task cnt_en(input int c);
		n = 0;
		repeat (c) begin
			@(posedge core_clk_in);
			if (cpu_en === 1'b1)
				n++;
		end
	endtask : cnt_en

	task pulse_halt;
		halt_req <= 1;
		tick(1);
		halt_req <= 0;
		tick(4);
	endtask : pulse_halt

	////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(8);
		rst_n_in <= 1;
		por_cmd <= 0;
		tick(2);
		chk("clk_sel", clk_sel, CKM_INT);
		chk("osc_en", osc_en, 1);
		wait_rel;
		chk("start delay", n >= START_CYC && n <= START_CYC + 40, 1);
		chk("start", start_p, 1);
		chk("boot", boot, VEC_RESET);
		apb(0, IDX_CPU_DIV, 0);
		chk("cpu_div", rd, RST_CPU_DIV);
		apb(0, IDX_OPT_TRIM, 0);
		chk("trim", rd, RST_TRIM);
		apb(0, IDX_OPT_LVD, 0);
		chk("lvd opt", rd, RST_LVD_LVL);
		apb(0, IDX_STATUS, 0);
		chk("state", rd[2:0], ST_RUN);
		apb(1, IDX_OPT_TRIM, 32'h28);
		chk("trim out", trim, 6'h28);
		apb(1, IDX_OPT_CLK, {27'h0, 3'h5, CKM_INT});
		chk("gain out", gain, 3'h5);
		for (int i = 0; i < 8; i++) begin
			apb(1, IDX_CPU_DIV, dv[i]);
			tick(70);
			cnt_en(128);
			chk("cpu strobes", n, ex[i]);
			chk("periph", per_en, 1);
		end
		apb(1, IDX_CPU_DIV, 0);
		for (int i = 3; i >= 0; i--) begin
			apb(1, IDX_OPT_LVD, i);
			chk("lvd level", lvd_lvl, i);
		end
		apb(1, IDX_OPT_LVD, 1);
		wait_req <= 1;
		tick(1);
		wait_req <= 0;
		tick(3);
		cnt_en(20);
		chk("wait cpu", n, 0);
		chk("wait periph", per_en, 1);
		irq <= 1;
		tick(1);
		irq <= 0;
		tick(3);
		cnt_en(20);
		chk("wait exit", n, 20);
		wdog_en <= 1;
		pulse_halt;
		chk("halt wdog", osc_en, 1);
		wdog_en <= 0;
		pulse_halt;
		chk("halt osc", {osc_en, per_en, lvd_en, cpu_en}, 0);
		port_irq <= 2'b01;
		tick(10);
		chk("masked port", osc_en, 0);
		port_irq <= 0;
		nmi <= 1;
		n = 0;
		while (resume !== 2'b01 && n < 20000) begin
			@(posedge core_clk_in);
			n++;
		end
		nmi <= 0;
		chk("halt exit", n >= START_CYC && n <= START_CYC + 40, 1);
		chk("resume", resume, 2'b01);
		chk("no reset", core_rst_n, 1);
		low_cmd <= 1;
		tick(30);
		low_cmd <= 0;
		tick(60);
		chk("spike", core_rst_n, 1);
		low_cmd <= 1;
		tick(60);
		chk("lvd rst", core_rst_n, 0);
		tick(100);
		chk("lvd hold", {core_rst_n, osc_en}, 1);
		low_cmd <= 0;
		wait_rel;
		chk("lvd rel", n >= LVD_FILT_CYC && n <= LVD_FILT_CYC + 6, 1);
		chk("lvd kept", lvd_lvl, 1);
		apb(0, IDX_STATUS, 0);
		chk("cause", rd[4:3], CAUSE_LVD);
		wdog_rst <= 1;
		tick(1);
		wdog_rst <= 0;
		tick(1);
		chk("wdog rst", core_rst_n, 0);
		wait_rel;
		chk("wdog rel", n <= 2 && osc_en === 1'b1, 1);
		apb(0, IDX_STATUS, 0);
		chk("cause", rd[4:3], CAUSE_WDOG);
		apb(1, IDX_OPT_CLK, {27'h0, RST_GAIN, CKM_EXT});
		chk("gain zero", gain, RST_GAIN);
		apb(1, IDX_OPT_WAKE, 1);
		apb(1, IDX_CPU_DIV, 6'h04);
		pin_cmd <= 1;
		tick(5);
		chk("pin rst", core_rst_n, 0);
		pin_cmd <= 0;
		tick(10);
		chk("start clk", clk_sel, CKM_INT);
		wait_rel;
		// count from the pin press, fifteen edges before the wait began
		n = n + 15;
		chk("ext delay", n >= START_CYC + 2 * WU && n <= START_CYC + 2 * WU + 40, 1);
		chk("mode ext", clk_sel, CKM_EXT);
		apb(0, IDX_CPU_DIV, 0);
		chk("div cleared", rd, RST_CPU_DIV);
		apb(1, 6'h3F, 32'hFF);
		chk("unmapped", err, 1);
		apb(0, 6'h3F, 0);
		chk("unmapped rd", rd, 32'h0000_0000);
		chk("unmapped rd err", err, 1);
		results();
	end
endmodule : tb
